// ### inc/lpt_pkg.sv
package lpt_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PRESC = 8'h04;
	localparam logic [7:0] ADDR_CMP = 8'h08;
	localparam logic [7:0] ADDR_CNT = 8'h0c;

	// ------------------------------------------------------------
	// control_status_reg fields
	// ------------------------------------------------------------
	localparam int CTRL_EN = 0;
	localparam int CTRL_PULSE_MODE = 1;
	localparam int CTRL_FREE_RUN = 2;
	localparam int CTRL_ACT_LOW = 3;
	localparam int CTRL_SRC_LO = 4;
	localparam int CTRL_IRQ_EN = 6;
	localparam int CTRL_FLAG = 7;

	// ------------------------------------------------------------
	// prescale_config_reg fields
	// ------------------------------------------------------------
	localparam int PRESC_CLK_LO = 0;
	localparam int PRESC_BYPASS = 2;
	localparam int PRESC_VAL_LO = 3;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// extra prescaler edges spent synchronising the first enable, minus one
	localparam logic [0:0] SYNC_EXTRA_M1 = 1'h1;

	typedef enum logic [1:0] {
		PH_OFF = 2'b00,
		PH_SYNC = 2'b01,
		PH_RUN = 2'b11
	} lpt_phase_type;

endpackage

// ### design/lpt_timer.sv
// Implementation choice: the plain strobed port.
module lpt_timer #(
	parameter int CNT_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_presc_clk,
	input wire logic [3:0] i_pulse_src,
	output logic [31:0] o_rd_data,
	output logic o_irq,
	output logic o_hw_trigger
);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
		$error("CNT_W must lie between 1 and 16");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic pulse_mode;
		logic free_run;
		logic act_low;
		logic [1:0] src_sel;
		logic irq_en;
		logic flag;
		logic [1:0] clk_sel;
		logic bypass;
		logic [3:0] presc;
		logic [CNT_W-1:0] cmp;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] hold;
		lpt_pkg::lpt_phase_type phase;
		logic sync_left;
		logic [15:0] pcnt;
		logic filt;
		logic clk_prev;
		logic src_prev;
		logic trig;
		logic irq;
		logic [31:0] rdata;
	} lpt_state_type;

	lpt_state_type s_q;
	lpt_state_type s_d;

	// mask of 2^(n+1)-1; wraps correctly at n=15
	function automatic logic [15:0] lpt_mask(input logic [3:0] n);
		lpt_mask = 16'((17'h0_0002 << n) - 17'h0_0001);
	endfunction

	// ------------------------------------------------------------
	// edge detection and increment sources
	// ------------------------------------------------------------
	logic clk_now;
	logic tick;
	logic src_now;
	logic [15:0] div_m1;
	logic [15:0] filt_m1;
	logic filt_hit;
	logic inc;
	logic match;

	assign clk_now = i_presc_clk[s_q.clk_sel];
	assign tick = clk_now & ~s_q.clk_prev;
	// asserted level is 1 whatever the source polarity
	assign src_now = i_pulse_src[s_q.src_sel] ^ s_q.act_low;
	assign div_m1 = lpt_mask(s_q.presc);
	assign filt_m1 = div_m1 >> 1;
	// input held at new level long enough
	assign filt_hit = (src_now != s_q.filt) && (s_q.pcnt == filt_m1);
	assign match = (s_q.cnt == s_q.cmp);

	always_comb begin
		inc = 1'b0;
		if (s_q.en) begin
			if (s_q.pulse_mode && s_q.bypass) begin
				inc = src_now & ~s_q.src_prev;
			end else if (s_q.phase == lpt_pkg::PH_RUN && tick) begin
				if (s_q.pulse_mode) begin
					inc = filt_hit & src_now;
				end else if (s_q.bypass) begin
					inc = 1'b1;
				end else begin
					inc = (s_q.pcnt == div_m1);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdata = lpt_pkg::RESET_WORD;
		s_d.clk_prev = clk_now;

		// prescaler / filter sequencing
		unique case (s_q.phase)
			lpt_pkg::PH_OFF: begin
				if (s_q.en) begin
					s_d.phase = lpt_pkg::PH_SYNC;
					s_d.sync_left = lpt_pkg::SYNC_EXTRA_M1;
				end
			end
			lpt_pkg::PH_SYNC: begin
				if (tick) begin
					if (s_q.sync_left == 1'b0) begin
						s_d.phase = lpt_pkg::PH_RUN;
					end else begin
						s_d.sync_left = 1'b0;
					end
				end
			end
			lpt_pkg::PH_RUN: begin
				if (tick && !s_q.bypass) begin
					if (s_q.pulse_mode) begin
						if (src_now == s_q.filt) begin
							s_d.pcnt = 16'h0000;
						end else if (filt_hit) begin
							s_d.filt = src_now;
							s_d.pcnt = 16'h0000;
						end else begin
							s_d.pcnt = s_q.pcnt + 16'h0001;
						end
					end else if (s_q.pcnt == div_m1) begin
						s_d.pcnt = 16'h0000;
					end else begin
						s_d.pcnt = s_q.pcnt + 16'h0001;
					end
				end
			end
			default: begin
				s_d.phase = lpt_pkg::PH_OFF;
			end
		endcase

		if (s_q.en) begin
			s_d.src_prev = src_now;
		end

		// counter and compare
		if (inc) begin
			if (match) begin
				s_d.flag = 1'b1;
				// trigger stays up while every step matches
				s_d.trig = 1'b1;
				s_d.cnt = s_q.free_run ? s_q.cnt + 1'b1 : '0;
			end else begin
				s_d.trig = 1'b0;
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end

		// register writes; a flag set in this cycle beats the clear
		if (i_wr) begin
			unique case (i_addr)
				lpt_pkg::ADDR_CTRL: begin
					s_d.en = i_wr_data[lpt_pkg::CTRL_EN];
					s_d.pulse_mode = i_wr_data[lpt_pkg::CTRL_PULSE_MODE];
					s_d.free_run = i_wr_data[lpt_pkg::CTRL_FREE_RUN];
					s_d.act_low = i_wr_data[lpt_pkg::CTRL_ACT_LOW];
					s_d.src_sel = i_wr_data[lpt_pkg::CTRL_SRC_LO +: 2];
					s_d.irq_en = i_wr_data[lpt_pkg::CTRL_IRQ_EN];
					if (i_wr_data[lpt_pkg::CTRL_FLAG] && !(inc && match)) begin
						s_d.flag = 1'b0;
					end
				end
				lpt_pkg::ADDR_PRESC: begin
					s_d.clk_sel = i_wr_data[lpt_pkg::PRESC_CLK_LO +: 2];
					s_d.bypass = i_wr_data[lpt_pkg::PRESC_BYPASS];
					s_d.presc = i_wr_data[lpt_pkg::PRESC_VAL_LO +: 4];
				end
				lpt_pkg::ADDR_CMP: begin
					// only the low bits are stored
					s_d.cmp = i_wr_data[CNT_W-1:0];
				end
				lpt_pkg::ADDR_CNT: begin
					s_d.hold = s_q.cnt;
				end
				default: begin
				end
			endcase
		end

		// disable clears count, flag and trigger
		if (!s_d.en) begin
			s_d.phase = lpt_pkg::PH_OFF;
			s_d.cnt = '0;
			s_d.flag = 1'b0;
			s_d.trig = 1'b0;
			s_d.pcnt = 16'h0000;
			s_d.sync_left = 1'b0;
			s_d.filt = 1'b1;
			// a source already high gives no edge
			s_d.src_prev = 1'b1;
		end

		s_d.irq = s_d.flag & s_d.irq_en;

		if (i_rd) begin
			unique case (i_addr)
				lpt_pkg::ADDR_CTRL: begin
					s_d.rdata[lpt_pkg::CTRL_EN] = s_q.en;
					s_d.rdata[lpt_pkg::CTRL_PULSE_MODE] = s_q.pulse_mode;
					s_d.rdata[lpt_pkg::CTRL_FREE_RUN] = s_q.free_run;
					s_d.rdata[lpt_pkg::CTRL_ACT_LOW] = s_q.act_low;
					s_d.rdata[lpt_pkg::CTRL_SRC_LO +: 2] = s_q.src_sel;
					s_d.rdata[lpt_pkg::CTRL_IRQ_EN] = s_q.irq_en;
					s_d.rdata[lpt_pkg::CTRL_FLAG] = s_q.flag;
				end
				lpt_pkg::ADDR_PRESC: begin
					s_d.rdata[lpt_pkg::PRESC_CLK_LO +: 2] = s_q.clk_sel;
					s_d.rdata[lpt_pkg::PRESC_BYPASS] = s_q.bypass;
					s_d.rdata[lpt_pkg::PRESC_VAL_LO +: 4] = s_q.presc;
				end
				lpt_pkg::ADDR_CMP: begin
					s_d.rdata[CNT_W-1:0] = s_q.cmp;
				end
				lpt_pkg::ADDR_CNT: begin
					s_d.rdata[CNT_W-1:0] = s_q.hold;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// the only reset is the power-on / low-voltage one
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
			s_q.filt <= 1'b1;
			s_q.src_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rd_data = s_q.rdata;
	assign o_irq = s_q.irq;
	assign o_hw_trigger = s_q.trig;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_compare;
		inc && match;
	endsequence

	sequence s_step_no_match;
		inc && !match;
	endsequence

	property p_flag_set;
		s_compare ##0 s_q.en
			&& !(i_wr && i_addr == lpt_pkg::ADDR_CTRL && !i_wr_data[lpt_pkg::CTRL_EN])
			|=> s_q.flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set on compare");

	property p_irq_gate;
		$rose(o_irq) |-> s_q.irq_en && s_q.flag;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable and flag");

	property p_irq_on;
		s_compare ##0 s_q.irq_en && !i_wr |=> o_irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missed on compare");

	property p_clear_on_cmp;
		s_compare ##0 (!s_q.free_run && !i_wr) |=> s_q.cnt == '0;
	endproperty
	a_clear_on_cmp: assert property (p_clear_on_cmp) else $error("count not cleared");

	property p_trig_on;
		s_compare ##0 s_q.en && !i_wr |=> o_hw_trigger;
	endproperty
	a_trig_on: assert property (p_trig_on) else $error("trigger missed");

	property p_trig_drop;
		s_step_no_match |=> !o_hw_trigger;
	endproperty
	a_trig_drop: assert property (p_trig_drop) else $error("trigger held past step");

	property p_trig_zero;
		o_hw_trigger && s_q.cmp == '0 && !s_q.free_run && !i_wr |=> o_hw_trigger;
	endproperty
	a_trig_zero: assert property (p_trig_zero) else $error("trigger dropped at zero");

	property p_upper_zero;
		i_rd && (i_addr == lpt_pkg::ADDR_CMP || i_addr == lpt_pkg::ADDR_CNT)
			|=> o_rd_data[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

	property p_off_clear;
		!s_q.en |-> s_q.cnt == '0 && !s_q.flag && !o_hw_trigger;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("disabled state not clear");

	property p_hold;
		i_wr && i_addr == lpt_pkg::ADDR_CNT ##1 i_rd && i_addr == lpt_pkg::ADDR_CNT
			|=> o_rd_data[CNT_W-1:0] == $past(s_q.cnt, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("read-back not latched count");

	property p_sync;
		$rose(s_q.phase == lpt_pkg::PH_SYNC) && !(s_q.pulse_mode && s_q.bypass)
			|-> !inc && s_q.sync_left;
	endproperty
	a_sync: assert property (p_sync) else $error("no synchronising delay");

	property p_force_src;
		!s_q.en |-> s_q.src_prev && s_q.filt;
	endproperty
	a_force_src: assert property (p_force_src) else $error("source not forced");

endmodule

// ### dv/lpt_src_model.sv
module lpt_src_model (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_level,
	output logic [3:0] o_presc_clk,
	output logic [3:0] o_pulse_src
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q [4];
	// four clocks, always running
	// half period of clock k is k+2 ref cycles, slow enough for edge detect
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_presc_clk <= 4'h0;
			o_pulse_src <= 4'h0;
			for (int k = 0; k < 4; k++) begin
				cnt_q[k] <= 4'h0;
			end
		end else begin
			o_pulse_src <= i_level;
			for (int k = 0; k < 4; k++) begin
				if (cnt_q[k] == 4'(k + 1)) begin
					cnt_q[k] <= 4'h0;
					o_presc_clk[k] <= ~o_presc_clk[k];
				end else begin
					cnt_q[k] <= cnt_q[k] + 4'h1;
				end
			end
		end
	end
endmodule

// ### dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] level = 4'h0;
	logic [3:0] presc_clk;
	logic [3:0] pulse_src;
	logic [31:0] o_rd_data;
	logic o_irq;
	logic o_hw_trigger;
	logic [31:0] rdat;
	int error_cnt = 0;
	int checked = 0;
	int seed = 51;
	int per;
	int n;
	always #4 i_ref_clk = ~i_ref_clk;
	lpt_src_model i_lpt_src_model (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.i_level(level), .o_presc_clk(presc_clk), .o_pulse_src(pulse_src));
	lpt_timer i_lpt_timer (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_presc_clk(presc_clk),
		.i_pulse_src(pulse_src), .o_rd_data(o_rd_data), .o_irq(o_irq),
		.o_hw_trigger(o_hw_trigger));
	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		rdat = o_rd_data;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic read_cnt();
		wr(lpt_pkg::ADDR_CNT, 32'(unsigned'($random(seed))));
		rd(lpt_pkg::ADDR_CNT);
	endtask
	// k source pulses on source 2, len ref cycles per level
	task automatic pulses(input int k, input int len);
		for (int p = 0; p < k; p++) begin
			repeat (len) @(posedge i_ref_clk);
			level <= 4'h0;
			repeat (len) @(posedge i_ref_clk);
			level <= 4'h4;
		end
	endtask
	// waits for a rising trigger, returns ref cycles taken
	// sampled on the falling edge, where the outputs have settled
	task automatic wait_rise(output int t);
		logic prev;
		prev = o_hw_trigger;
		t = 0;
		forever begin
			@(negedge i_ref_clk);
			t++;
			if (o_hw_trigger === 1'b1 && prev !== 1'b1) begin
				break;
			end
			prev = o_hw_trigger;
			if (t > 3000) begin
				error_cnt++;
				$display("FAIL %0t no trigger", $time);
				complete_run();
			end
		end
	endtask
	// two increments per compare event with compare 1, count cleared
	function automatic int exp_per(int sel, bit byp, int nv);
		return 4 * (sel + 2) * (byp ? 1 : (2 ** (nv + 1)));
	endfunction
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#80000;
		error_cnt++;
		complete_run();
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		rd(lpt_pkg::ADDR_CMP);
		chk(rdat, lpt_pkg::RESET_WORD);
		read_cnt();
		chk(rdat, lpt_pkg::RESET_WORD);
		rd(8'h10);
		chk(rdat, 32'h0000_0000);
		wr(lpt_pkg::ADDR_CMP, 32'hffff_ffff);
		rd(lpt_pkg::ADDR_CMP);
		chk(rdat, 32'h0000_ffff);
		for (int s = 0; s < 5; s++) begin
			// control written disabled first, irq enable last
			wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
			wr(lpt_pkg::ADDR_PRESC, (s < 4) ? 32'(4 + s) : 32'h0000_0008);
			wr(lpt_pkg::ADDR_CMP, 32'h0000_0001);
			wr(lpt_pkg::ADDR_CTRL, 32'h0000_0041);
			wait_rise(per);
			repeat (2) @(negedge i_ref_clk);
			chk(32'(o_irq), 32'h0000_0001);
			rd(lpt_pkg::ADDR_CTRL);
			chk(32'(rdat[lpt_pkg::CTRL_FLAG]), 32'h0000_0001);
			wait_rise(per);
			wait_rise(per);
			chk(32'(per), 32'(exp_per(s % 4, s < 4, 1)));
			wr(lpt_pkg::ADDR_CTRL, 32'h0000_0081);
			repeat (2) @(negedge i_ref_clk);
			chk(32'(o_irq), 32'h0000_0000);
			wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
			repeat (2) @(negedge i_ref_clk);
			chk(32'(o_hw_trigger), 32'h0000_0000);
			read_cnt();
			chk(rdat, 32'h0000_0000);
		end
		wr(lpt_pkg::ADDR_PRESC, 32'h0000_0004);
		wr(lpt_pkg::ADDR_CMP, 32'h0000_0000);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0001);
		wait_rise(per);
		repeat (60) @(negedge i_ref_clk);
		chk(32'(o_hw_trigger), 32'h0000_0001);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
		level <= 4'h4;
		wr(lpt_pkg::ADDR_CMP, 32'h0000_0003);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0027);
		n = 1 + ($random(seed) & 7);
		pulses(n, 3);
		repeat (4) @(posedge i_ref_clk);
		read_cnt();
		// free-running past compare; no count from the high start
		chk(rdat, 32'(n));
		chk(32'(o_hw_trigger), 32'(n == 4));
		rd(lpt_pkg::ADDR_CTRL);
		chk(32'(rdat[lpt_pkg::CTRL_FLAG]), 32'(n >= 4));
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
		// filter starts asserted and ignores a one-cycle glitch
		wr(lpt_pkg::ADDR_PRESC, 32'h0000_0008);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0027);
		n = 1 + ($random(seed) & 3);
		pulses(n, 20);
		repeat (20) @(posedge i_ref_clk);
		level <= 4'h0;
		@(posedge i_ref_clk);
		level <= 4'h4;
		repeat (20) @(posedge i_ref_clk);
		read_cnt();
		chk(rdat, 32'(n));
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(lpt_pkg::ADDR_PRESC, 32'h0000_0004);
		wr(lpt_pkg::ADDR_CMP, 32'h0000_0001);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0023);
		pulses(2, 3);
		repeat (4) @(posedge i_ref_clk);
		// compare rewritten only while the flag is set
		wr(lpt_pkg::ADDR_CMP, 32'h0000_0002);
		// flag cleared before the count reaches the new compare
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_00a3);
		rd(lpt_pkg::ADDR_CTRL);
		chk(32'(rdat[lpt_pkg::CTRL_FLAG]), 32'h0000_0000);
		pulses(3, 3);
		repeat (4) @(posedge i_ref_clk);
		rd(lpt_pkg::ADDR_CTRL);
		chk(32'(rdat[lpt_pkg::CTRL_FLAG]), 32'h0000_0001);
		read_cnt();
		chk(rdat, 32'h0000_0000);
		chk(32'(o_hw_trigger), 32'h0000_0001);
		wr(lpt_pkg::ADDR_CTRL, 32'h0000_0000);
		complete_run();
	end
endmodule
